/* File: common/cigx_regs.vh */
// Constants for the instruction execution core: opcodes, widths, resets.
`ifndef CIGX_REGS_VH
`define CIGX_REGS_VH

// ************************************************************
// Widths
// ************************************************************
`define CIGX_INSTR_W 14
`define CIGX_DATA_W 8
`define CIGX_PC_W 15
`define CIGX_FADDR_W 7
`define CIGX_LATCH_W 7
`define CIGX_FILE_DEPTH 128

// ************************************************************
// Opcode fields and encodings
// ************************************************************
// Byte-oriented and literal groups are told apart by bits 13:8.
`define CIGX_OP_HI 13
`define CIGX_OP_LO 8
`define CIGX_OP_INCR_SKIP 6'h0f
`define CIGX_OP_INCR 6'h0a
`define CIGX_OP_OR_FILE 6'h04
`define CIGX_OP_SHL 6'h35
`define CIGX_OP_OR_LIT 6'h38
// The branch is told apart by bits 13:11 alone.
`define CIGX_BR_HI 13
`define CIGX_BR_LO 11
`define CIGX_OP_BRANCH 3'h5
// Destination select bit and operand fields.
`define CIGX_DEST_BIT 7
`define CIGX_FADDR_HI 6
`define CIGX_LIT_HI 7
`define CIGX_BR_K_HI 10
// Latch bits that fill the upper program counter on a branch.
`define CIGX_LATCH_HI 6
`define CIGX_LATCH_LO 3

// ************************************************************
// Reset values
// ************************************************************
`define CIGX_PC_RST 15'h0000
`define CIGX_W_RST 8'h00
`define CIGX_FLAG_RST 1'h0

// ************************************************************
// Instruction cycle counts
// ************************************************************
`define CIGX_CYC_ONE 2'h1
`define CIGX_CYC_TWO 2'h2

`endif

/* File: rtl/cigx_file_ram.v */
// File register memory with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none
`include "cigx_regs.vh"

module cigx_file_ram (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Read port
  input wire [`CIGX_FADDR_W-1:0] rd_addr_i,
  output reg [`CIGX_DATA_W-1:0] rd_data_o,
  // Write port
  input wire wr_en_i,
  input wire [`CIGX_FADDR_W-1:0] wr_addr_i,
  input wire [`CIGX_DATA_W-1:0] wr_data_i
);

  reg [`CIGX_DATA_W-1:0] mem_q [0:`CIGX_FILE_DEPTH-1];

  // ************************************************************
  // Storage
  // ************************************************************
  // The array has no reset so that it maps onto plain RAM.
  always @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data is registered; a same-edge write is not seen until later.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule // cigx_file_ram
`default_nettype wire

/* File: rtl/cigx_core.v */
// Execution core for increment, OR, left shift and branch instructions.
//
// How it works
// - Destination bit 0 sends the result to W, 1 back to the file.
// - Increment-skip: zero result swaps the next instruction for a no-op.
// - Branch loads its 11-bit operand into program counter bits 10:0.
// - Branch fills program counter bits 14:11 from latch bits 6:3.
// - Branch always takes two cycles and leaves all flags alone.
// - OR-literal ORs W with the 8-bit literal into W, updates zero.
// - Increment adds one to the file, routes result, updates zero only.
// - OR-file ORs W with the file, routes result, updates zero.
// - Left shift: bit 7 to carry, bits 6:0 up, zero in, carry and zero.
`timescale 1ns/1ns
`default_nettype none
`include "cigx_regs.vh"

module cigx_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Instruction handshake
  input wire instr_valid_i,
  input wire [`CIGX_INSTR_W-1:0] instr_i,
  output reg instr_ready_o,
  // Program counter latch contents
  input wire [`CIGX_LATCH_W-1:0] program_counter_latch_i,
  // Architectural state
  output reg [`CIGX_PC_W-1:0] pc_o,
  output reg [`CIGX_DATA_W-1:0] work_o,
  output reg carry_o,
  output reg zero_o,
  // Retirement report
  output reg retire_o,
  output reg [1:0] retire_cycles_o,
  // File write mirror
  output reg file_wr_o,
  output reg [`CIGX_FADDR_W-1:0] file_addr_o,
  output reg [`CIGX_DATA_W-1:0] file_data_o
);

  // ************************************************************
  // Local codes
  // ************************************************************
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_EXEC = 2'h1;
  localparam [1:0] S_NOOP = 2'h2;

  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_INCR_SKIP = 3'h1;
  localparam [2:0] K_BRANCH = 3'h2;
  localparam [2:0] K_OR_LIT = 3'h3;
  localparam [2:0] K_INCR = 3'h4;
  localparam [2:0] K_OR_FILE = 3'h5;
  localparam [2:0] K_SHL = 3'h6;

  // ************************************************************
  // Functions
  // ************************************************************
  // Sorts an instruction word into one of the handled kinds.
  function [2:0] kind_of;
    input [`CIGX_INSTR_W-1:0] word;
    reg [5:0] op;
    begin
      op = word[`CIGX_OP_HI:`CIGX_OP_LO];
      if (word[`CIGX_BR_HI:`CIGX_BR_LO] == `CIGX_OP_BRANCH)
        kind_of = K_BRANCH;
      else if (op == `CIGX_OP_INCR_SKIP)
        kind_of = K_INCR_SKIP;
      else if (op == `CIGX_OP_OR_LIT)
        kind_of = K_OR_LIT;
      else if (op == `CIGX_OP_INCR)
        kind_of = K_INCR;
      else if (op == `CIGX_OP_OR_FILE)
        kind_of = K_OR_FILE;
      else if (op == `CIGX_OP_SHL)
        kind_of = K_SHL;
      else
        kind_of = K_NONE;
    end
  endfunction

  // Zero test shared by every flag-updating kind.
  function is_zero;
    input [`CIGX_DATA_W-1:0] value;
    begin
      is_zero = (value == 8'h00);
    end
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`CIGX_INSTR_W-1:0] instr_q;
  reg [`CIGX_PC_W-1:0] pc_d;
  reg [`CIGX_DATA_W-1:0] w_d;
  reg carry_d;
  reg zero_d;
  reg [`CIGX_DATA_W-1:0] result;
  reg to_file;
  reg two_cycle;
  wire [`CIGX_DATA_W-1:0] file_rd_data;
  wire accept;
  wire [2:0] kind;
  wire [`CIGX_FADDR_W-1:0] f_addr;
  wire dest_file;
  wire [`CIGX_DATA_W-1:0] sum;

  assign accept = instr_valid_i & instr_ready_o;
  assign kind = kind_of(instr_q);
  assign f_addr = instr_q[`CIGX_FADDR_HI:0];
  assign dest_file = instr_q[`CIGX_DEST_BIT];
  // Increment wraps 8'hff to 8'h00, which is what the skip looks for.
  assign sum = file_rd_data + 8'h01;

  // ************************************************************
  // File registers
  // ************************************************************
  // The read is started from the raw word as it is taken, so the
  // operand is ready in the execute cycle without a stall.
  cigx_file_ram u_file (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rd_addr_i(instr_i[`CIGX_FADDR_HI:0]),
    .rd_data_o(file_rd_data),
    .wr_en_i(to_file),
    .wr_addr_i(f_addr),
    .wr_data_i(result)
  );

  // ************************************************************
  // Execute
  // ************************************************************
  // Computes the result, its destination, flags and next counter.
  always @*
  begin
    w_d = work_o;
    carry_d = carry_o;
    zero_d = zero_o;
    pc_d = pc_o + 15'h0001;
    result = 8'h00;
    to_file = 1'b0;
    two_cycle = 1'b0;
    if (state_q == S_EXEC)
    begin
      case (kind)
        K_INCR_SKIP:
        begin
          result = sum;
          // No flag is touched here, the zero test only steers the skip.
          if (is_zero(sum))
          begin
            pc_d = pc_o + 15'h0002;
            two_cycle = 1'b1;
          end
        end
        K_BRANCH:
        begin
          pc_d = {program_counter_latch_i[`CIGX_LATCH_HI:`CIGX_LATCH_LO],
                  instr_q[`CIGX_BR_K_HI:0]};
          two_cycle = 1'b1;
        end
        K_OR_LIT:
        begin
          w_d = work_o | instr_q[`CIGX_LIT_HI:0];
          zero_d = is_zero(w_d);
        end
        K_INCR:
        begin
          result = sum;
          zero_d = is_zero(sum);
        end
        K_OR_FILE:
        begin
          result = work_o | file_rd_data;
          zero_d = is_zero(result);
        end
        K_SHL:
        begin
          result = {file_rd_data[6:0], 1'b0};
          carry_d = file_rd_data[7];
          zero_d = is_zero(result);
        end
        default:
        begin
          result = 8'h00;
        end
      endcase
      // File-result kinds route by the destination bit.
      if (kind == K_INCR_SKIP || kind == K_INCR || kind == K_OR_FILE ||
          kind == K_SHL)
      begin
        if (dest_file)
          to_file = 1'b1;
        else
          w_d = result;
      end
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // The no-op cycle keeps the next word out, which is how a skipped
  // instruction and the branch refill both cost one extra cycle.
  always @*
  begin
    case (state_q)
      S_IDLE:
        state_d = accept ? S_EXEC : S_IDLE;
      S_EXEC:
        state_d = two_cycle ? S_NOOP : S_IDLE;
      S_NOOP:
        state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  // State, handshake and the taken instruction word.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      instr_ready_o <= 1'b0;
      instr_q <= 14'h0000;
    end
    else
    begin
      state_q <= state_d;
      instr_ready_o <= (state_d == S_IDLE);
      if (accept)
      begin
        instr_q <= instr_i;
      end
    end
  end

  // ************************************************************
  // Architectural registers and reports
  // ************************************************************
  // Counter, W and flags update only on the execute edge, so flags never move in between.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_o <= `CIGX_PC_RST;
      work_o <= `CIGX_W_RST;
      carry_o <= `CIGX_FLAG_RST;
      zero_o <= `CIGX_FLAG_RST;
      retire_o <= 1'b0;
      retire_cycles_o <= 2'h0;
      file_wr_o <= 1'b0;
      file_addr_o <= 7'h00;
      file_data_o <= 8'h00;
    end
    else
    begin
      retire_o <= (state_q == S_EXEC);
      file_wr_o <= to_file;
      if (state_q == S_EXEC)
      begin
        pc_o <= pc_d;
        work_o <= w_d;
        carry_o <= carry_d;
        zero_o <= zero_d;
        retire_cycles_o <= two_cycle ? `CIGX_CYC_TWO : `CIGX_CYC_ONE;
        file_addr_o <= f_addr;
        file_data_o <= result;
      end
    end
  end

endmodule // cigx_core
`default_nettype wire

/* File: testbench/cigx_core_assertions.sv */
// Assertions on the execution core's ports.
`timescale 1ns/1ns
`default_nettype none
`include "cigx_regs.vh"
module cigx_core_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction side
  input wire logic instr_valid_i,
  input wire logic [`CIGX_INSTR_W-1:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic [`CIGX_LATCH_W-1:0] program_counter_latch_i,
  // State and retirement
  input wire logic [`CIGX_PC_W-1:0] pc_o,
  input wire logic [`CIGX_DATA_W-1:0] work_o,
  input wire logic carry_o,
  input wire logic zero_o,
  input wire logic retire_o,
  input wire logic [1:0] retire_cycles_o,
  input wire logic file_wr_o,
  input wire logic [`CIGX_FADDR_W-1:0] file_addr_o,
  input wire logic [`CIGX_DATA_W-1:0] file_data_o
);
  // ****************************
  // Capture of the taken word
  // ****************************
  // The state before each word is kept so every result ties to its cause.
  logic [13:0] word_q;
  logic [7:0] w_q;
  logic [6:0] lat_q;
  logic c_q, z_q;
  wire logic take = instr_valid_i && instr_ready_o;
  wire logic [5:0] op = word_q[13:8];
  wire logic br = word_q[13:11] == `CIGX_OP_BRANCH;
  wire logic fop = op == `CIGX_OP_INCR || op == `CIGX_OP_INCR_SKIP
    || op == `CIGX_OP_OR_FILE || op == `CIGX_OP_SHL;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      {word_q, w_q, lat_q, c_q, z_q} <= '0;
    else
    begin
      lat_q <= program_counter_latch_i;
      if (take)
        {word_q, w_q, c_q, z_q} <= {instr_i, work_o, carry_o, zero_o};
    end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_exec;
    !instr_ready_o ##1 retire_o;
  endsequence
  sequence s_slow;
    !instr_ready_o ##1 instr_ready_o;
  endsequence
  property p_take;
    take |=> s_exec;
  endproperty
  property p_slow;
    retire_o && retire_cycles_o == 2'h2 |-> s_slow;
  endproperty
  property p_fast;
    retire_o && retire_cycles_o == 2'h1 |-> instr_ready_o;
  endproperty
  property p_br_pc;
    retire_o && br |-> pc_o == {lat_q[6:3], word_q[10:0]};
  endproperty
  property p_br_keep;
    retire_o && br |-> retire_cycles_o == 2'h2 && carry_o == c_q
      && zero_o == z_q && !file_wr_o;
  endproperty
  property p_dest;
    retire_o && fop |-> file_wr_o == word_q[7] && file_addr_o == word_q[6:0]
      && work_o == (word_q[7] ? w_q : file_data_o);
  endproperty
  property p_skip;
    retire_o && op == `CIGX_OP_INCR_SKIP |-> {carry_o, zero_o} == {c_q, z_q}
      && (retire_cycles_o == 2'h2) == (file_data_o == 8'h00);
  endproperty
  property p_or_lit;
    retire_o && op == `CIGX_OP_OR_LIT |-> work_o == (w_q | word_q[7:0])
      && zero_o == (work_o == 8'h00);
  endproperty
  property p_zero;
    retire_o && fop && op != `CIGX_OP_INCR_SKIP
      |-> zero_o == (file_data_o == 8'h00);
  endproperty
  property p_shl;
    retire_o && op == `CIGX_OP_SHL |-> !file_data_o[0];
  endproperty
  property p_or_file;
    retire_o && op == `CIGX_OP_OR_FILE |-> (file_data_o & w_q) == w_q;
  endproperty
  property p_carry_kept;
    retire_o && (op == `CIGX_OP_INCR || op == `CIGX_OP_OR_FILE)
      |-> carry_o == c_q;
  endproperty
  a_take: assert property (p_take) else $error("no retire");
  a_slow: assert property (p_slow) else $error("slow ready");
  a_fast: assert property (p_fast) else $error("fast ready wrong");
  a_br_pc: assert property (p_br_pc) else $error("branch pc");
  a_br_keep: assert property (p_br_keep) else $error("branch cost");
  a_dest: assert property (p_dest) else $error("result routing");
  a_skip: assert property (p_skip) else $error("skip wrong");
  a_or_lit: assert property (p_or_lit) else $error("or lit");
  a_zero: assert property (p_zero) else $error("zero flag");
  a_shl: assert property (p_shl) else $error("shift fill");
  a_or_file: assert property (p_or_file) else $error("file or");
  a_carry_kept: assert property (p_carry_kept) else $error("carry");
endmodule // cigx_core_assertions
bind cigx_core cigx_core_assertions u_assert (
  .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
  .program_counter_latch_i(program_counter_latch_i), .work_o(work_o),
  .carry_o(carry_o), .zero_o(zero_o), .retire_o(retire_o),
  .retire_cycles_o(retire_cycles_o), .file_wr_o(file_wr_o),
  .file_addr_o(file_addr_o), .file_data_o(file_data_o));
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the execution core.
`timescale 1ns/1ns
`default_nettype none
`include "cigx_regs.vh"
module tb;
  // ****************************
  // Ports, model and counters
  // ****************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [6:0] program_counter_latch_i = 7'h00;
  wire logic instr_ready_o, carry_o, zero_o, retire_o, file_wr_o;
  wire logic [14:0] pc_o;
  wire logic [7:0] work_o, file_data_o;
  wire logic [1:0] retire_cycles_o;
  wire logic [6:0] file_addr_o;
  // The file model mirrors the memory; both are cleared at time zero,
  // because an unknown cell would turn the flags unknown as well.
  logic [7:0] fm [0:127];
  logic [14:0] m_pc = 15'h0000;
  logic [7:0] m_w = 8'h00;
  logic m_c = 1'b0;
  logic m_z = 1'b0;
  logic [43:0] exq [$];
  logic [43:0] e;
  logic [31:0] r;
  logic [5:0] kops [0:3] = '{`CIGX_OP_INCR_SKIP, `CIGX_OP_INCR,
    `CIGX_OP_OR_FILE, `CIGX_OP_SHL};
  int bad_count = 0;
  int checked = 0;
  int seed = 20;
  int n;
  cigx_core DUT (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
    .program_counter_latch_i(program_counter_latch_i), .work_o(work_o),
    .carry_o(carry_o), .zero_o(zero_o), .retire_o(retire_o),
    .retire_cycles_o(retire_cycles_o), .file_wr_o(file_wr_o),
    .file_addr_o(file_addr_o), .file_data_o(file_data_o));
  initial
    forever #2 clk_i = ~clk_i;
  task automatic cmp(input logic [14:0] got, exp, input string what);
    begin
      checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Works out the expected outcome, notes it, then offers the word.
  task automatic issue(input logic [13:0] w, input logic chk);
    logic [5:0] op;
    logic [7:0] v;
    logic [7:0] res;
    logic [1:0] cy;
    logic fop;
    begin
      for (n = 0; n < 8 && instr_ready_o !== 1'b1; n++)
        @(negedge clk_i);
      if (instr_ready_o !== 1'b1)
      begin
        bad_count++;
        results();
      end
      program_counter_latch_i = 7'($random(seed));
      op = w[13:8];
      v = fm[w[6:0]];
      res = 8'h00;
      cy = 2'h1;
      m_pc = m_pc + 15'h1;
      fop = op == `CIGX_OP_INCR || op == `CIGX_OP_INCR_SKIP
        || op == `CIGX_OP_OR_FILE || op == `CIGX_OP_SHL;
      case (op)
        `CIGX_OP_INCR, `CIGX_OP_INCR_SKIP: res = v + 8'h01;
        `CIGX_OP_OR_FILE: res = v | m_w;
        `CIGX_OP_SHL: {m_c, res} = {v, 1'b0};
        `CIGX_OP_OR_LIT: res = m_w | w[7:0];
        default: ;
      endcase
      if (op == `CIGX_OP_INCR_SKIP && res == 8'h00)
      begin
        m_pc = m_pc + 15'h1;
        cy = 2'h2;
      end
      else if (op != `CIGX_OP_INCR_SKIP && (fop || op == `CIGX_OP_OR_LIT))
        m_z = res == 8'h00;
      if (w[13:11] == `CIGX_OP_BRANCH)
      begin
        m_pc = {program_counter_latch_i[6:3], w[10:0]};
        cy = 2'h2;
      end
      if (fop && w[7])
        fm[w[6:0]] = res;
      else if (fop || op == `CIGX_OP_OR_LIT)
        m_w = res;
      exq.push_back({chk, m_pc, m_w, m_c, m_z, cy, fop & w[7], w[6:0], res});
      instr_i = w;
      instr_valid_i = 1'b1;
      @(negedge clk_i);
      instr_valid_i = 1'b0;
    end
  endtask
  // Eight shifts clear the cell whatever it held; only then is it checked.
  task automatic load(input logic [6:0] a, input logic [7:0] v);
    begin
      repeat (8)
        issue({`CIGX_OP_SHL, 1'b1, a}, 1'b0);
      issue({`CIGX_OP_SHL, 1'b0, a}, 1'b1);
      issue({`CIGX_OP_OR_LIT, v}, 1'b1);
      issue({`CIGX_OP_OR_FILE, 1'b1, a}, 1'b1);
    end
  endtask
  // Each retirement takes the oldest note and compares it if the note is marked for checking.
  always @(negedge clk_i)
    if (retire_o === 1'b1)
    begin
      if (exq.size() == 0)
        cmp(15'h1, 15'h0, "extra retire");
      else
      begin
        e = exq.pop_front();
        if (e[43])
        begin
          cmp(pc_o, e[42:28], "pc");
          cmp(work_o, e[27:20], "work");
          cmp({carry_o, zero_o}, e[19:18], "flags");
          cmp(retire_cycles_o, e[17:16], "cycles");
          cmp(file_wr_o, e[15], "write");
          if (e[15])
            cmp({file_addr_o, file_data_o}, e[14:0], "file");
        end
      end
    end
  // ****************************
  // Main sequence
  // ****************************
  initial
  begin
    // The memory has no reset, so the bench clears it and its model.
    for (int i = 0; i < 128; i++)
    begin
      DUT.u_file.mem_q[i] = 8'h00;
      fm[i] = 8'h00;
    end
    repeat (12)
      @(negedge clk_i);
    rst_i = 1'b0;
    for (int a = 0; a < 4; a++)
      load(a[6:0], a == 0 ? 8'hff : a == 1 ? 8'h80 : a == 2 ? 8'h00 : 8'h5a);
    $display("test load done");
    issue({`CIGX_OP_INCR_SKIP, 1'b0, 7'h00}, 1'b1);
    issue({`CIGX_OP_INCR, 1'b1, 7'h00}, 1'b1);
    issue({`CIGX_OP_SHL, 1'b0, 7'h01}, 1'b1);
    issue({`CIGX_OP_INCR_SKIP, 1'b1, 7'h02}, 1'b1);
    issue({`CIGX_OP_BRANCH, 11'h7ff}, 1'b1);
    issue({`CIGX_OP_BRANCH, 11'h000}, 1'b1);
    issue(14'h0000, 1'b1);
    $display("test directed done");
    for (int i = 0; i < 300; i++)
    begin
      r = $random(seed);
      if (r[14:12] > 3'h4)
        issue({`CIGX_OP_BRANCH, r[10:0]}, 1'b1);
      else if (r[14:12] == 3'h4)
        issue({`CIGX_OP_OR_LIT, r[7:0]}, 1'b1);
      else
        issue({kops[r[13:12]], r[7], 5'h00, r[1:0]}, 1'b1);
    end
    for (n = 0; n < 20 && exq.size() > 0; n++)
      @(negedge clk_i);
    if (exq.size() > 0)
      bad_count++;
    $display("test random done");
    results();
  end
endmodule // tb
`default_nettype wire
